// ===== verilog/adc_seq_pkg.sv
// constants, field layout and types shared by the conversion sequencer
// assumes a 32-bit classic wishbone slave with byte addresses
package adc_seq_pkg;
   // ***************
   // register map
   // ***************
   // printed offsets are not multiples of four: they are indices, byte address = 4 * index
   localparam logic [7:0]  IDX_CONTROL_STATUS = 8'h45;
   localparam logic [7:0]  IDX_RESULT_HIGH    = 8'h46;
   localparam logic [7:0]  IDX_RESULT_LOW     = 8'h47;
   localparam logic [7:0]  RESET_CONTROL      = 8'h00;
   localparam logic [9:0]  RESET_RESULT       = 10'h000;
   // ***************
   // control/status fields
   // ***************
   localparam int          BIT_DONE           = 7;
   localparam int          BIT_SPEED          = 6;
   localparam int          BIT_POWER_ON       = 5;
   localparam int          BIT_SLOW           = 4;
   localparam int          SELECT_MSB         = 3;
   // ***************
   // timing
   // ***************
   localparam int          CPU_CLOCK_HZ       = 25000000;
   localparam int          FAST_LIMIT_HZ      = 4000000;
   localparam int          CONV_CYCLES        = 12;
   localparam int          DIV_FULL           = 1;
   localparam int          DIV_HALF           = 2;
   localparam int          DIV_QUARTER        = 4;
   typedef enum logic [1:0] {IDLE, CONVERT} seq_state_type;
endpackage

// ===== verilog/conv_result_store.sv
// holds the two result bytes seen by software
// assumes the sequencer decides when to load
`timescale 1ns/10ps
`default_nettype none
module conv_result_store #(
   parameter int WIDTH = 10
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   // load side
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadData,
   // read side
   output logic      [WIDTH-1:0] resultData
);
   typedef struct packed {
      logic [WIDTH-1:0] data;
   } store_type;
   store_type state_r;
   store_type state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (load) begin
         state_nxt.data = loadData;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r.data <= WIDTH'(adc_seq_pkg::RESET_RESULT);
      end else begin
         state_r <= state_nxt;
      end
   end

   assign resultData = state_r.data;
endmodule
`default_nettype wire

// ===== verilog/adc_conversion_sequencer.sv
// control side of a 10-bit successive approximation converter
// assumes the analog core delivers an unclamped 10-bit code on convCode, sampled at end of conversion
`timescale 1ns/10ps
`default_nettype none
// Function
// - an input above the high reference reports full scale ff/03 with no overflow flag.
// - an input below the low reference reports zero in both result registers.
// - setting power-on starts conversion, repeated continuously on the selected input.
// - each finished conversion sets the done flag at bit 7 and stores the result unless locked.
// - reading the high result or writing control/status clears the done flag.
// - writing a new input select aborts the conversion, clears done and restarts.
// - reading the low result locks both result registers.
// - reading the high result or clearing power-on unlocks the results.
// - while locked, finished conversions do not overwrite the results.
// - clearing power-on disables the converter and stops any conversion.
// - slow and speed select cpu/2, cpu, cpu/4 or cpu/2 as converter clock.
// - the four-bit select field picks analog input 0 to 15.
// - high result holds bits 9:2, low result holds bits 1:0 with zero above.
// - done is read only, the other control bits are read and write.
// - wait mode has no effect, halt mode disables the converter.
module adc_conversion_sequencer #(
   parameter int CONV_CYCLES = adc_seq_pkg::CONV_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // cpu power modes
   input  wire logic        haltMode,
   input  wire logic        waitMode,
   // analog core
   output logic             converterPowerOn,
   output logic [3:0]       inputSelectField,
   output logic             sampleStart,
   input  wire logic        aboveHighReference,
   input  wire logic        belowLowReference,
   input  wire logic [9:0]  convCode
);
   // ***************
   // state
   // ***************
   typedef struct packed {
      logic [7:0]                 control;
      logic                       done;
      logic                       locked;
      adc_seq_pkg::seq_state_type seq;
      logic [1:0]                 divCount;
      logic [7:0]                 convCount;
      logic                       ack;
      logic                       err;
      logic [31:0]                rdata;
      logic                       start;
      logic                       halt1;
      logic                       halt2;
      logic                       over1;
      logic                       over2;
      logic                       under1;
      logic                       under2;
      logic [9:0]                 code1;
      logic [9:0]                 code2;
   } seq_type;
   seq_type state_r;
   seq_type state_nxt;

   logic       storeLoad;
   logic [9:0] storeIn;
   logic [9:0] result;

   // last divider count of a converter clock period, one less than the period in cpu cycles
   function automatic logic [1:0] divTop(input logic slow, input logic speed);
      logic [1:0] top;
      top = 2'(adc_seq_pkg::DIV_HALF - 1);
      if (!slow && speed) begin
         top = 2'(adc_seq_pkg::DIV_FULL - 1);
      end else if (slow && !speed) begin
         top = 2'(adc_seq_pkg::DIV_QUARTER - 1);
      end
      return top;
   endfunction

   // final code after reference clamping
   function automatic logic [9:0] clampCode(input logic over, input logic under,
                                            input logic [9:0] code);
      logic [9:0] value;
      value = code;
      if (over) begin
         value = 10'h3ff;
      end else if (under) begin
         value = 10'h000;
      end
      return value;
   endfunction

   conv_result_store #(
      .WIDTH      (10)
   ) u_store (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .load       (storeLoad),
      .loadData   (storeIn),
      .resultData (result)
   );

   // ***************
   // next state
   // ***************
   logic        access;
   logic        isControl;
   logic        isHigh;
   logic        isLow;
   logic        mapped;
   logic        running;
   logic        convTick;
   logic        convEnd;
   logic [7:0]  wrByte;
   logic [29:0] ctrlIdx;

   always_comb begin
      state_nxt = state_r;
      storeLoad = 1'b0;
      storeIn   = clampCode(state_r.over2, state_r.under2, state_r.code2);
      // full word index compared, so no register shows up again higher in the map
      ctrlIdx   = wb_adr_i[31:2];
      // a new request is only taken while ack is low, giving one ack per access
      access    = wb_cyc_i && wb_stb_i && !state_r.ack && !state_r.err;
      isControl = (ctrlIdx == 30'(adc_seq_pkg::IDX_CONTROL_STATUS));
      isHigh    = (ctrlIdx == 30'(adc_seq_pkg::IDX_RESULT_HIGH));
      isLow     = (ctrlIdx == 30'(adc_seq_pkg::IDX_RESULT_LOW));
      mapped    = isControl || isHigh || isLow;
      wrByte    = wb_dat_i[7:0];
      state_nxt.ack   = access && mapped;
      state_nxt.err   = access && !mapped;
      state_nxt.start = 1'b0;
      // pin level synchronisers
      state_nxt.halt1  = haltMode;
      state_nxt.halt2  = state_r.halt1;
      state_nxt.over1  = aboveHighReference;
      state_nxt.over2  = state_r.over1;
      state_nxt.under1 = belowLowReference;
      state_nxt.under2 = state_r.under1;
      state_nxt.code1  = convCode;
      state_nxt.code2  = state_r.code1;
      // wait mode is ignored on purpose: the converter keeps running
      running  = state_r.control[adc_seq_pkg::BIT_POWER_ON] && !state_r.halt2;
      convTick = (state_r.divCount == divTop(state_r.control[adc_seq_pkg::BIT_SLOW],
                                             state_r.control[adc_seq_pkg::BIT_SPEED]));
      convEnd  = convTick && (state_r.convCount == 8'(CONV_CYCLES - 1));

      // sequencer
      unique case (state_r.seq)
         adc_seq_pkg::IDLE: begin
            state_nxt.divCount  = '0;
            state_nxt.convCount = '0;
            if (running) begin
               state_nxt.seq   = adc_seq_pkg::CONVERT;
               state_nxt.start = 1'b1;
            end
         end
         adc_seq_pkg::CONVERT: begin
            state_nxt.divCount = convTick ? 2'b00 : state_r.divCount + 2'b01;
            if (convTick) begin
               state_nxt.convCount = state_r.convCount + 8'h01;
            end
            if (!running) begin
               state_nxt.seq = adc_seq_pkg::IDLE;
            end else if (convEnd) begin
               // restart at once for continuous conversion
               state_nxt.convCount = '0;
               state_nxt.start     = 1'b1;
               state_nxt.done      = 1'b1;
               if (!state_r.locked) begin
                  storeLoad = 1'b1;
               end
            end
         end
         default: begin
            state_nxt.seq = adc_seq_pkg::IDLE;
         end
      endcase

      // bus reads: clears take lower priority than a completing conversion
      if (access && !wb_we_i) begin
         state_nxt.rdata = '0;
         if (isControl) begin
            state_nxt.rdata[7:0] = {state_r.done, state_r.control[6:0]};
         end else if (isHigh) begin
            state_nxt.rdata[7:0] = result[9:2];
            state_nxt.locked     = 1'b0;
            if (!(state_r.seq == adc_seq_pkg::CONVERT && running && convEnd)) begin
               state_nxt.done = 1'b0;
            end
         end else if (isLow) begin
            state_nxt.rdata[7:0] = {6'h00, result[1:0]};
            state_nxt.locked     = 1'b1;
         end
      end

      // bus writes to control/status, byte lane 0 only
      if (access && wb_we_i && isControl && wb_sel_i[0]) begin
         state_nxt.control[6:0] = wrByte[6:0];
         if (!(state_r.seq == adc_seq_pkg::CONVERT && running && convEnd)) begin
            state_nxt.done = 1'b0;
         end
         if (wrByte[3:0] != state_r.control[3:0]) begin
            // abort and restart on the new input, new conversion ends later so clear wins
            state_nxt.done      = 1'b0;
            state_nxt.divCount  = '0;
            state_nxt.convCount = '0;
            state_nxt.seq       = adc_seq_pkg::IDLE;
            // an aborted conversion must not leave a start pulse behind the restart
            state_nxt.start     = 1'b0;
            storeLoad           = 1'b0;
         end
         if (!wrByte[adc_seq_pkg::BIT_POWER_ON]) begin
            state_nxt.locked = 1'b0;
            state_nxt.seq    = adc_seq_pkg::IDLE;
            state_nxt.start  = 1'b0;
         end
      end
   end

   // ***************
   // registers
   // ***************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r         <= '0;
         state_r.control <= adc_seq_pkg::RESET_CONTROL;
         state_r.seq     <= adc_seq_pkg::IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ***************
   // outputs
   // ***************
   assign wb_ack_o         = state_r.ack;
   assign wb_err_o         = state_r.err;
   assign wb_dat_o         = state_r.rdata;
   assign converterPowerOn = running;
   assign inputSelectField = state_r.control[adc_seq_pkg::SELECT_MSB:0];
   assign sampleStart      = state_r.start;
endmodule
`default_nettype wire

// ===== dv/adc_core_model.sv
// stand-in for the analog multiplexer and converter core
// assumes the bench sets the presented code and input range
`timescale 1ns/10ps
`default_nettype none
module adc_core_model (
   // from the sequencer
   input  wire logic       sys_clk,
   input  wire logic       converterPowerOn,
   // from the bench: 1 above high reference, 2 below low reference
   input  wire logic [1:0] rangeMode,
   input  wire logic [9:0] codeIn,
   // to the sequencer
   output logic            aboveHighReference,
   output logic            belowLowReference,
   output logic      [9:0] convCode = 10'h155
);
   // an unpowered core shows a moving pattern, never a held last code
   always_ff @(posedge sys_clk) begin
      aboveHighReference <= converterPowerOn && rangeMode == 2'h1;
      belowLowReference  <= converterPowerOn && rangeMode == 2'h2;
      convCode           <= converterPowerOn ? codeIn : ~convCode;
   end
endmodule
`default_nettype wire

// ===== dv/adc_conversion_sequencer_properties.sv
// port checker for the conversion sequencer
// assumes byte address = 4 * register index
`timescale 1ns/10ps
`default_nettype none
module adc_seq_properties (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        haltMode,
   input wire logic        converterPowerOn,
   input wire logic [3:0]  inputSelectField,
   input wire logic        sampleStart
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic req, mapped, rd;
   assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign mapped = wb_adr_i inside {32'h114, 32'h118, 32'h11c};
   assign rd     = wb_ack_o && !wb_we_i;
   a_answer_next: assert property (req |=> wb_ack_o != wb_err_o)
      else $error("request not answered next cycle");
   a_err_unmapped: assert property (req |=> wb_err_o == !$past(mapped))
      else $error("error answer does not match address");
   a_read_upper: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_low_reserved: assert property (rd && wb_adr_i == 32'h11c |-> wb_dat_o[7:2] == 6'h0)
      else $error("low result reserved bits not zero");
   a_select_write: assert property ($changed(inputSelectField) |->
      wb_ack_o && wb_we_i && wb_adr_i == 32'h114)
      else $error("input select changed without control write");
   a_halt_off: assert property (haltMode [*5] |-> !converterPowerOn)
      else $error("converter powered during halt");
   a_power_starts: assert property ($rose(converterPowerOn) |=> sampleStart)
      else $error("no conversion start after power on");
   a_off_quiet: assert property (!converterPowerOn [*2] |-> !sampleStart)
      else $error("conversion start while powered off");
   a_start_gap: assert property (sampleStart |=> !sampleStart)
      else $error("conversion shorter than two cycles");
   cover property (rd && wb_adr_i == 32'h11c);
   cover property (wb_err_o);
   cover property ($rose(converterPowerOn));
endmodule
bind adc_conversion_sequencer adc_seq_properties adc_seq_properties_i (.sys_clk, .arst_n,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
   .haltMode, .converterPowerOn, .inputSelectField, .sampleStart);
`default_nettype wire

// ===== dv/tb_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
// assumes the core model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module tb_adc_conversion_sequencer;
   // long conversions leave room for several bus reads between results
   localparam int CONV = 40;
   localparam logic [31:0] CTRL = 32'h114, HIGH = 32'h118, LOW = 32'h11c;
   logic sys_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, we = 1'b0, halt = 1'b0, waitM = 1'b0;
   logic [31:0] adr = '0, wdat = '0, rdat;
   logic ack, err, pwr, start, above, below;
   logic [3:0] sel;
   logic [9:0] code, codeIn = '0;
   logic [1:0] mode = '0;
   int failures = 0, comparisons = 0;
   logic [32:0] notes[$];
   adc_conversion_sequencer #(.CONV_CYCLES(CONV)) adc_conversion_sequencer_i (.sys_clk,
      .arst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
      .haltMode(halt), .waitMode(waitM), .converterPowerOn(pwr), .inputSelectField(sel),
      .sampleStart(start), .aboveHighReference(above), .belowLowReference(below),
      .convCode(code));
   adc_core_model adc_core_model_i (.sys_clk, .converterPowerOn(pwr), .rangeMode(mode),
      .codeIn, .aboveHighReference(above), .belowLowReference(below), .convCode(code));
   initial forever #20 sys_clk = ~sys_clk;
   // ***************
   // tasks
   // ***************
   task automatic check(string what, logic [32:0] exp, logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic bus(logic w, logic [31:0] a, logic [7:0] d);
      @(posedge sys_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge sys_clk); while (ack !== 1'b1 && err !== 1'b1);
      cyc <= 1'b0;
   endtask
   task automatic rd(logic [31:0] a, logic [32:0] exp);
      notes.push_back(exp);
      bus(1'b0, a, 8'h0);
   endtask
   task automatic waitStart(output int n);
      n = 0;
      do begin @(posedge sys_clk); n++; end while (start !== 1'b1);
   endtask
   always @(posedge sys_clk)
      if ((ack === 1'b1 || err === 1'b1) && we === 1'b0)
         check("read", notes.size() ? notes.pop_front() : 'x,
               {err, err ? 32'h0 : rdat});
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      end_of_test();
   end
   // ***************
   // tests
   // ***************
   initial begin
      int g0, n;
      int gaps[4];
      logic [9:0] c, e, e2;
      logic [7:0] ctl;
      void'($urandom(14));
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(CTRL, 33'h0);
      rd(HIGH, 33'h0);
      rd(LOW, 33'h0);
      rd(32'h120, 33'h1_00000000);
      bus(1'b1, CTRL, 8'h8f);
      bus(1'b1, HIGH, 8'hff);
      rd(CTRL, 33'h0f);
      rd(HIGH, 33'h0);
      $display("test registers done");
      waitM <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         mode <= (k < 2) ? 2'(k + 1) : 2'h0;
         c = 10'($urandom);
         codeIn <= c;
         e = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : c;
         e2 = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : ~c;
         ctl = {1'b0, k[0], 1'b1, k[1], 2'(k), 2'($urandom)};
         bus(1'b1, CTRL, ctl);
         waitStart(g0);
         check("restart", 33'h1, {32'h0, g0 <= 3});
         check("select", {29'h0, ctl[3:0]}, {29'h0, sel});
         // a full conversion separates these two starts
         waitStart(gaps[k]);
         rd(CTRL, {25'h0, 1'b1, ctl[6:0]});
         rd(LOW, {31'h0, e[1:0]});
         codeIn <= ~c;
         waitStart(g0);
         waitStart(g0);
         rd(HIGH, {25'h0, e[9:2]});
         rd(CTRL, {25'h0, 1'b0, ctl[6:0]});
         waitStart(g0);
         rd(LOW, {31'h0, e2[1:0]});
         rd(HIGH, {25'h0, e2[9:2]});
         // a write that keeps the input must still clear done, and bit 7 stays read only
         waitStart(g0);
         rd(CTRL, {25'h0, 1'b1, ctl[6:0]});
         bus(1'b1, CTRL, ctl | 8'h80);
         rd(CTRL, {25'h0, 1'b0, ctl[6:0]});
         $display("test conversion %0d done", k);
      end
      check("div4", 33'(3 * CONV), 33'(gaps[2] - gaps[1]));
      check("div2", 33'(CONV), 33'(gaps[0] - gaps[1]));
      check("div2b", 33'(gaps[0]), 33'(gaps[3]));
      halt <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check("halt", 33'h0, {32'h0, pwr});
      bus(1'b1, CTRL, 8'h00);
      halt <= 1'b0;
      n = 0;
      repeat (200) begin
         @(posedge sys_clk);
         if (start === 1'b1) n++;
      end
      check("stopped", 33'h0, 33'(n));
      check("power", 33'h0, {32'h0, pwr});
      $display("test power modes done");
      end_of_test();
   end
endmodule
`default_nettype wire
